// File: hdl/sadc_cfg.svh
// Timing and layout constants of the serial converter link.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
// ==========================================================================
// Data width and conversion sequence
// ==========================================================================
`define SADC_DATA_W 8
`define SADC_HOLD_CYCLES 4
`define SADC_CONV_CYCLES 32
`define SADC_TOTAL_CYCLES 36
`define SADC_CYC_W 6
// ==========================================================================
// Times in nanoseconds and the system clock period
// ==========================================================================
`define SADC_CLK_NS 25
`define SADC_CONV_MAX_NS 17000
`define SADC_SETUP_NS 1400
`define SADC_REPEAT_NS 22000
`define SADC_HALF_SCLK_NS 225
// Least times round up to whole cycles.
`define SADC_NS_TO_CYC(ns) (((ns) + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_SETUP_CYC `SADC_NS_TO_CYC(`SADC_SETUP_NS)
`define SADC_REPEAT_CYC `SADC_NS_TO_CYC(`SADC_REPEAT_NS)
`define SADC_HALF_CYC `SADC_NS_TO_CYC(`SADC_HALF_SCLK_NS)
`define SADC_CONV_MAX_CYC (`SADC_CONV_MAX_NS / `SADC_CLK_NS)
`define SADC_FIFO_DEPTH 4
`endif

// File: hdl/sadc_device.sv
// Converter end: select filter, serial result shifter and conversion sequencer.
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_device #(
    parameter int DATA_W = `SADC_DATA_W,
    parameter int HOLD_CYCLES = `SADC_HOLD_CYCLES,
    parameter int CONV_CYCLES = `SADC_CONV_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    sadc_link_if.adc link,
    input wire logic [DATA_W-1:0] analog_in,
    output logic sampling,
    output logic holding,
    output logic converting,
    output logic conv_done,
    output logic [DATA_W-1:0] result
);
    // ======================================================================
    // Declarations
    // ======================================================================
    localparam int CNT_W = $clog2(DATA_W);
    localparam int HALF_BITS = DATA_W / 2;
    localparam logic [`SADC_CYC_W-1:0] HOLD_LAST = `SADC_CYC_W'(HOLD_CYCLES - 1);
    localparam logic [`SADC_CYC_W-1:0] CONV_LAST = `SADC_CYC_W'(CONV_CYCLES - 1);
    localparam int STEP_CYC = CONV_CYCLES / DATA_W;

    logic cs_s1_reg;
    logic cs_s2_reg;
    logic sel_high_reg;
    logic sel_high_prev_reg;
    logic sel_fall;
    logic oe_reg;

    logic [CNT_W-1:0] edge_cnt_reg;
    logic [CNT_W-1:0] edge_cnt_next;
    logic samp_reg;
    logic hold_tgl_reg;

    logic trig_s1_reg;
    logic trig_s2_reg;
    logic trig_s3_reg;
    logic trig;

    logic [DATA_W-1:0] ain_s1_reg;
    logic [DATA_W-1:0] ain_s2_reg;
    logic [DATA_W-1:0] held_reg;
    logic [DATA_W-1:0] sar_reg;
    logic [DATA_W-1:0] trial;
    logic [DATA_W-1:0] result_reg;
    logic done_reg;

    sadc_pkg::sadc_conv_state_type state_reg;
    logic [`SADC_CYC_W-1:0] cyc_reg;

    // Index of the bit under trial for a given conversion cycle.
    function automatic logic [CNT_W-1:0] trial_bit(input logic [`SADC_CYC_W-1:0] cyc);
        logic [`SADC_CYC_W-1:0] step;
        step = cyc / `SADC_CYC_W'(STEP_CYC);
        trial_bit = CNT_W'(DATA_W - 1) - step[CNT_W-1:0];
    endfunction : trial_bit

    // ======================================================================
    // Select recognition on the system clock
    // ======================================================================
    // Two rising edges pass select through a synchroniser.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
        end else begin
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
        end
    end

    // The following falling edge completes the noise filter.
    always_ff @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_high_reg <= 1'b1;
        end else begin
            sel_high_reg <= cs_s2_reg;
        end
    end

    // The previous recognised level lets a select fall be seen as an event.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_high_prev_reg <= 1'b1;
        end else begin
            sel_high_prev_reg <= sel_high_reg;
        end
    end

    assign sel_fall = sel_high_prev_reg & ~sel_high_reg;

    // Output enable turns on once select is recognised low, and the raw pin
    // clears it at once on a rise, ahead of the filtered level.
    always_ff @(posedge clk or negedge arst_n or posedge link.cs_n) begin
        if (!arst_n) begin
            oe_reg <= 1'b0;
        end else if (link.cs_n) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= ~sel_high_reg;
        end
    end

    assign link.dout_oe = oe_reg;

    // ======================================================================
    // Shift clock domain
    // ======================================================================
    // Count wraps after eight edges so select may stay low for many frames.
    assign edge_cnt_next = edge_cnt_reg + CNT_W'(1);

    // Edge count and sampling window, held cleared while select reads high.
    always_ff @(negedge link.sclk or negedge arst_n or posedge sel_high_reg) begin
        if (!arst_n) begin
            edge_cnt_reg <= '0;
            samp_reg <= 1'b0;
        end else if (sel_high_reg) begin
            edge_cnt_reg <= '0;
            samp_reg <= 1'b0;
        end else begin
            edge_cnt_reg <= edge_cnt_next;
            samp_reg <= (edge_cnt_next >= CNT_W'(HALF_BITS));
        end
    end

    // The eighth falling edge toggles a flag that hands the hold to clk.
    always_ff @(negedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            hold_tgl_reg <= 1'b0;
        end else if (!sel_high_reg && edge_cnt_reg == CNT_W'(DATA_W - 1)) begin
            hold_tgl_reg <= ~hold_tgl_reg;
        end
    end

    // MSB while the count is zero, then one lower bit per falling edge.
    assign link.dout = result_reg[CNT_W'(DATA_W - 1) - edge_cnt_reg];
    assign sampling = samp_reg;

    // ======================================================================
    // Crossing into the system clock domain
    // ======================================================================
    // The hold toggle is synchronised, then compared for its edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
        end else begin
            trig_s1_reg <= hold_tgl_reg;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end

    assign trig = trig_s2_reg ^ trig_s3_reg;

    // The analog level is a slow quantity, synchronised before it is held.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ain_s1_reg <= '0;
            ain_s2_reg <= '0;
        end else begin
            ain_s1_reg <= analog_in;
            ain_s2_reg <= ain_s1_reg;
        end
    end

    // ======================================================================
    // Hold and conversion sequencer
    // ======================================================================
    // A recognised select fall aborts; a new hold restarts the sequence.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= sadc_pkg::SADC_CV_IDLE;
            cyc_reg <= '0;
        end else if (sel_fall) begin
            state_reg <= sadc_pkg::SADC_CV_IDLE;
            cyc_reg <= '0;
        end else if (trig) begin
            state_reg <= sadc_pkg::SADC_CV_HOLD;
            cyc_reg <= '0;
        end else begin
            case (state_reg)
                sadc_pkg::SADC_CV_HOLD: begin
                    if (cyc_reg == HOLD_LAST) begin
                        state_reg <= sadc_pkg::SADC_CV_CONV;
                        cyc_reg <= '0;
                    end else begin
                        cyc_reg <= cyc_reg + `SADC_CYC_W'(1);
                    end
                end
                sadc_pkg::SADC_CV_CONV: begin
                    if (cyc_reg == CONV_LAST) begin
                        state_reg <= sadc_pkg::SADC_CV_DONE;
                        cyc_reg <= '0;
                    end else begin
                        cyc_reg <= cyc_reg + `SADC_CYC_W'(1);
                    end
                end
                sadc_pkg::SADC_CV_DONE: begin
                    state_reg <= sadc_pkg::SADC_CV_IDLE;
                end
                default: begin
                    state_reg <= sadc_pkg::SADC_CV_IDLE;
                end
            endcase
        end
    end

    // The sample is frozen at the start of the hold.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held_reg <= '0;
        end else if (trig) begin
            held_reg <= ain_s2_reg;
        end
    end

    assign trial = sar_reg | (DATA_W'(1) << trial_bit(cyc_reg));

    // One bit is decided at the end of each step of the conversion.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sar_reg <= '0;
        end else if (trig) begin
            sar_reg <= '0;
        end else if (state_reg == sadc_pkg::SADC_CV_CONV &&
                     cyc_reg % `SADC_CYC_W'(STEP_CYC) == `SADC_CYC_W'(STEP_CYC - 1)) begin
            if (trial <= held_reg) begin
                sar_reg <= trial;
            end
        end
    end

    // Only a completed conversion replaces the result shifted out.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg == sadc_pkg::SADC_CV_DONE && !sel_fall && !trig) begin
                result_reg <= sar_reg;
                done_reg <= 1'b1;
            end
        end
    end

    assign holding = (state_reg == sadc_pkg::SADC_CV_HOLD);
    assign converting = (state_reg == sadc_pkg::SADC_CV_CONV);
    assign conv_done = done_reg;
    assign result = result_reg;
endmodule : sadc_device

// File: hdl/sadc_host.sv
// Controller end: frame generator for the converter and its result FIFO.
`timescale 1ns/1ps
`include "sadc_cfg.svh"
// ==========================================================================
// Result FIFO
// ==========================================================================
module sadc_fifo #(
    parameter int WIDTH = `SADC_DATA_W,
    parameter int DEPTH = `SADC_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_reg];

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth; the count gives honest full and empty.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : sadc_fifo

// ==========================================================================
// Frame generator
// ==========================================================================
module sadc_host #(
    parameter int DATA_W = `SADC_DATA_W,
    parameter int SETUP_CYC = `SADC_SETUP_CYC,
    parameter int HALF_CYC = `SADC_HALF_CYC,
    parameter int GAP_CYC = `SADC_REPEAT_CYC - `SADC_SETUP_CYC - 2 * `SADC_DATA_W * `SADC_HALF_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    sadc_link_if.ctl link,
    input wire logic start,
    output logic busy,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DATA_W-1:0] rd_data
);
    localparam int TW = 12;
    logic cs_n_reg;
    logic sclk_reg;
    logic busy_reg;
    logic d_s1_reg;
    logic d_s2_reg;
    logic [DATA_W-1:0] shift_reg;
    logic [3:0] fall_reg;
    logic [TW-1:0] tmr_reg;
    logic push_reg;
    logic fifo_ready;
    sadc_pkg::sadc_host_state_type state_reg;

    // The data line is a pin and passes two flip-flops.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_s1_reg <= 1'b0;
            d_s2_reg <= 1'b0;
        end else begin
            d_s1_reg <= link.data_line;
            d_s2_reg <= d_s1_reg;
        end
    end

    // Frame: select low, setup wait, eight clocks, select high for the gap.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= sadc_pkg::SADC_HS_IDLE;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            busy_reg <= 1'b0;
            tmr_reg <= '0;
            fall_reg <= '0;
            shift_reg <= '0;
            push_reg <= 1'b0;
        end else begin
            push_reg <= 1'b0;
            case (state_reg)
                sadc_pkg::SADC_HS_IDLE: begin
                    if (start && fifo_ready) begin
                        state_reg <= sadc_pkg::SADC_HS_SETUP;
                        cs_n_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        tmr_reg <= TW'(SETUP_CYC - 1);
                    end
                end
                sadc_pkg::SADC_HS_SETUP: begin
                    if (tmr_reg == '0) begin
                        state_reg <= sadc_pkg::SADC_HS_SHIFT;
                        sclk_reg <= 1'b1;
                        fall_reg <= '0;
                        tmr_reg <= TW'(HALF_CYC - 1);
                    end else begin
                        tmr_reg <= tmr_reg - TW'(1);
                    end
                end
                sadc_pkg::SADC_HS_SHIFT: begin
                    if (tmr_reg != '0) begin
                        tmr_reg <= tmr_reg - TW'(1);
                    end else if (sclk_reg) begin
                        sclk_reg <= 1'b0;
                        shift_reg <= {shift_reg[DATA_W-2:0], d_s2_reg};
                        fall_reg <= fall_reg + 4'h1;
                        tmr_reg <= TW'(HALF_CYC - 1);
                    end else if (fall_reg == 4'(DATA_W)) begin
                        state_reg <= sadc_pkg::SADC_HS_GAP;
                        cs_n_reg <= 1'b1;
                        push_reg <= 1'b1;
                        tmr_reg <= TW'(GAP_CYC - 1);
                    end else begin
                        sclk_reg <= 1'b1;
                        tmr_reg <= TW'(HALF_CYC - 1);
                    end
                end
                sadc_pkg::SADC_HS_GAP: begin
                    if (tmr_reg == '0) begin
                        state_reg <= sadc_pkg::SADC_HS_IDLE;
                        busy_reg <= 1'b0;
                    end else begin
                        tmr_reg <= tmr_reg - TW'(1);
                    end
                end
                default: begin
                    state_reg <= sadc_pkg::SADC_HS_IDLE;
                end
            endcase
        end
    end

    sadc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(`SADC_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push_reg),
        .in_ready(fifo_ready),
        .in_data(shift_reg),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign busy = busy_reg;
endmodule : sadc_host

// File: hdl/sadc_link_if.sv
// Three-wire link between the converter and its controller.
`timescale 1ns/1ps
interface sadc_link_if;
    logic cs_n;
    logic sclk;
    logic dout;
    logic dout_oe;
    wire data_line;

    // A pull-up holds the result line high while the converter does not drive it.
    assign data_line = dout_oe ? dout : 1'b1;

    modport adc (
        input cs_n,
        input sclk,
        output dout,
        output dout_oe
    );

    modport ctl (
        output cs_n,
        output sclk,
        input data_line
    );
endinterface : sadc_link_if

// File: hdl/sadc_pkg.sv
// Types shared by both ends of the serial converter link.
package sadc_pkg;
    // ======================================================================
    // Converter and host state machines
    // ======================================================================
    typedef enum logic [1:0] {
        SADC_CV_IDLE = 2'h0,
        SADC_CV_HOLD = 2'h1,
        SADC_CV_CONV = 2'h3,
        SADC_CV_DONE = 2'h2
    } sadc_conv_state_type;

    typedef enum logic [1:0] {
        SADC_HS_IDLE = 2'h0,
        SADC_HS_SETUP = 2'h1,
        SADC_HS_SHIFT = 2'h3,
        SADC_HS_GAP = 2'h2
    } sadc_host_state_type;
endpackage : sadc_pkg

// File: verif/sadc_link_sva.sv
// Link checker: select filter, bit timing and controller framing.
`timescale 1ns/1ps
module sadc_link_sva #(
    parameter int SETUP_CYC = 4,
    parameter int HALF_CYC = 2,
    parameter int GAP_CYC = 40
) (
    input wire logic clk,
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe
);
    // ==================================================================
    // Helper counters in the controller clock domain
    // ==================================================================
    logic sclk_old_reg;
    logic [3:0] fall_cnt_reg;
    logic [15:0] lvl_cnt_reg;
    logic [15:0] low_cnt_reg;
    logic [15:0] high_cnt_reg;
    // Shift clock history and the length of its current level.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_old_reg <= 1'b0;
            lvl_cnt_reg <= 16'h0000;
        end else begin
            sclk_old_reg <= sclk;
            lvl_cnt_reg <= (sclk != sclk_old_reg) ? 16'h0001 : lvl_cnt_reg + 16'h0001;
        end
    end
    // Cycles with select low and high; high starts saturated so the first frame passes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_reg <= 16'h0000;
            high_cnt_reg <= 16'hffff;
        end else begin
            low_cnt_reg <= cs_n ? 16'h0000 : low_cnt_reg + 16'h0001;
            high_cnt_reg <= cs_n ? high_cnt_reg + {15'h0000, ~&high_cnt_reg} : 16'h0000;
        end
    end
    // Falling shift clock edges within one frame.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_cnt_reg <= 4'h0;
        end else if (cs_n) begin
            fall_cnt_reg <= 4'h0;
        end else if (sclk_old_reg && !sclk) begin
            fall_cnt_reg <= fall_cnt_reg + 4'h1;
        end
    end
    // ==================================================================
    // Assertions
    // ==================================================================
    sequence s_sel_fall;
        $fell(cs_n);
    endsequence
    sequence s_sel_low_run;
        !cs_n [*6];
    endsequence
    a_float_when_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cs_n |-> !dout_oe) else $error("output driven while deselected");
    a_filter_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_sel_fall |-> !dout_oe [*2]) else $error("output enabled before filter");
    a_enable_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_sel_fall ##1 s_sel_low_run |-> dout_oe) else $error("output not enabled");
    a_bit_steady: assert property (@(posedge sys_clk) disable iff (!arst_n)
        dout_oe && sclk && $past(dout_oe) && $past(sclk) |-> $stable(dout))
        else $error("result bit moved while clock high");
    a_level_hold: assert property (@(posedge clk) disable iff (!arst_n)
        sclk != sclk_old_reg |-> lvl_cnt_reg >= HALF_CYC) else $error("short clock level");
    a_setup_kept: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(sclk) |-> low_cnt_reg >= SETUP_CYC) else $error("clock before setup");
    a_frame_eight: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(cs_n) |-> fall_cnt_reg == 4'h8) else $error("frame not eight clocks");
    a_gap_held: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(cs_n) |-> high_cnt_reg >= GAP_CYC) else $error("select gap too short");
endmodule : sadc_link_sva

// File: verif/test_serial_adc_conversion_sequencer.sv
// Bench: controller and converter joined, plus a converter driven by hand.
`timescale 1ns/1ps
module test_serial_adc_conversion_sequencer;
    typedef struct {
        logic [7:0] ain;
        logic [7:0] rd;
    } sadc_row_type;
    // ==================================================================
    // Clocks, signals and instances
    // ==================================================================
    logic clk = 1'b0;
    logic dclk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic rd_ready = 1'b0;
    logic [7:0] ain = 8'h00;
    logic [7:0] ain2 = 8'h00;
    logic busy, rd_valid, samp2, hold2, conv2, done2;
    logic [7:0] rd_data, result, result2;
    logic [15:0] got;
    int num_errors = 0;
    int checks_done = 0;
    int dones = 0;
    int holds = 0;
    int convs = 0;
    int d0, h0, c0;
    sadc_row_type rows [6] = '{'{8'h00, 8'h00}, '{8'hff, 8'h00}, '{8'ha5, 8'hff},
        '{8'h5a, 8'ha5}, '{8'h80, 8'h5a}, '{8'h01, 8'h80}};
    sadc_link_if link ();
    sadc_link_if link2 ();
    // Controller clock 25 ns; converter clock 12 ns, unrelated to it.
    always #12.5 clk = ~clk;
    always #6 dclk = ~dclk;
    sadc_device sadc_device_i (.clk(dclk), .arst_n(arst_n), .link(link), .analog_in(ain),
        .sampling(), .holding(), .converting(), .conv_done(), .result(result));
    sadc_device sadc_device_i2 (.clk(dclk), .arst_n(arst_n), .link(link2), .analog_in(ain2),
        .sampling(samp2), .holding(hold2), .converting(conv2), .conv_done(done2),
        .result(result2));
    sadc_host #(.SETUP_CYC(4), .HALF_CYC(2), .GAP_CYC(40)) sadc_host_i (.clk(clk),
        .arst_n(arst_n), .link(link), .start(start), .busy(busy), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));
    sadc_link_sva sadc_link_sva_i (.clk(clk),
        .sys_clk(dclk), .arst_n(arst_n), .cs_n(link.cs_n), .sclk(link.sclk),
        .dout(link.dout), .dout_oe(link.dout_oe));
    // Counts hold, convert and done cycles of the hand-driven converter at the quiet edge.
    always @(negedge dclk) begin
        holds += int'(hold2 === 1'b1);
        convs += int'(conv2 === 1'b1);
        dones += int'(done2 === 1'b1);
    end
    // ==================================================================
    // Tasks
    // ==================================================================
    task automatic cmp_bit(input logic act, input logic exp, input string what);
        checks_done++;
        if (act !== exp) begin
            num_errors++;
            $display("BAD %0t %s: got %b want %b", $time, what, act, exp);
        end
    endtask : cmp_bit
    task automatic cmp_byte(input logic [7:0] act, input logic [7:0] exp, input string what);
        checks_done++;
        if (act !== exp) begin
            num_errors++;
            $display("BAD %0t %s: got %h want %h", $time, what, act, exp);
        end
    endtask : cmp_byte
    // Waits on busy or read valid with a bound, so a hang shows as a mismatch.
    task automatic wait_for(input logic sel, input logic val);
        int n;
        n = 0;
        while ((sel ? rd_valid : busy) !== val && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmp_bit(1'(n < 3000), 1'b1, "wait");
    endtask : wait_for
    task automatic run_frame(input logic [7:0] val, input logic take);
        @(negedge clk);
        ain = val;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        cmp_bit(busy, take, "start");
        wait_for(1'b0, 1'b0);
    endtask : run_frame
    task automatic pop(input logic [7:0] exp);
        @(negedge clk);
        wait_for(1'b1, 1'b1);
        cmp_byte(rd_data, exp, "read");
        rd_ready = 1'b1;
        @(negedge clk);
        rd_ready = 1'b0;
    endtask : pop
    // Drives n shift clock periods on the second link and collects the bits.
    task automatic shift2(input int n, input int half, input logic act);
        got = 16'h0000;
        for (int k = 0; k <= n; k++) begin
            repeat (half) @(negedge clk);
            cmp_bit(samp2, 1'(act && k % 8 >= 4), "sampling");
            if (k == n) break;
            link2.sclk = 1'b1;
            got = {got[14:0], link2.data_line};
            repeat (half) @(negedge clk);
            link2.sclk = 1'b0;
        end
    endtask : shift2
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    // ==================================================================
    // Tests
    // ==================================================================
    // Cuts a hang short; the run needs about 30 us.
    initial begin
        #200000;
        num_errors++;
        $display("BAD %0t timeout", $time);
        stop_test();
    end
    // Main sequence: reset, table of frames, buffer, hand-driven link.
    initial begin
        link2.cs_n = 1'b1;
        link2.sclk = 1'b0;
        repeat (8) @(posedge clk);
        cmp_bit(link.dout_oe, 1'b0, "oe in reset");
        cmp_bit(link.cs_n, 1'b1, "select in reset");
        cmp_bit(busy, 1'b0, "busy in reset");
        cmp_byte(result, 8'h00, "result in reset");
        @(negedge clk);
        arst_n = 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            run_frame(rows[i].ain, 1'b1);
            cmp_byte(result, rows[i].ain, "result");
            pop(rows[i].rd);
        end
        $display("test table done");
        for (int k = 1; k <= 4; k++) run_frame(8'(8'h11 * k), 1'b1);
        run_frame(8'h55, 1'b0);
        for (int k = 0; k < 4; k++) pop(k == 0 ? 8'h01 : 8'(8'h11 * k));
        @(negedge clk);
        cmp_bit(rd_valid, 1'b0, "drained");
        $display("test buffer done");
        d0 = dones;
        shift2(8, 2, 1'b0);
        repeat (60) @(negedge clk);
        cmp_bit(link2.dout_oe, 1'b0, "oe deselected");
        cmp_byte(8'(dones - d0), 8'h00, "no conversion");
        link2.cs_n = 1'b0;
        @(posedge dclk);
        #1 cmp_bit(link2.dout_oe, 1'b0, "filter");
        repeat (4) @(negedge clk);
        cmp_bit(link2.dout_oe, 1'b1, "oe on");
        ain2 = 8'hc3;
        h0 = holds;
        c0 = convs;
        d0 = dones;
        shift2(8, 2, 1'b1);
        repeat (60) @(negedge clk);
        cmp_byte(result2, 8'hc3, "converted");
        cmp_byte(8'(holds - h0), 8'h04, "hold cycles");
        cmp_byte(8'(convs - c0), 8'h20, "convert cycles");
        cmp_byte(8'(dones - d0), 8'h01, "done once");
        ain2 = 8'h96;
        h0 = holds;
        d0 = dones;
        shift2(16, 1, 1'b1);
        cmp_byte(got[15:8], 8'hc3, "first of two");
        cmp_byte(got[7:0], 8'hc3, "second of two");
        repeat (60) @(negedge clk);
        cmp_byte(result2, 8'h96, "restarted");
        cmp_byte(8'(dones - d0), 8'h01, "one completion");
        cmp_byte(8'(holds - h0), 8'h08, "two holds");
        ain2 = 8'h5a;
        d0 = dones;
        shift2(8, 2, 1'b1);
        cmp_byte(got[7:0], 8'h96, "after restart");
        cmp_bit(link2.dout_oe, 1'b1, "oe before rise");
        link2.cs_n = 1'b1;
        #1 cmp_bit(link2.dout_oe, 1'b0, "oe released");
        repeat (5) @(negedge clk);
        link2.cs_n = 1'b0;
        repeat (60) @(negedge clk);
        cmp_byte(result2, 8'h96, "aborted");
        cmp_byte(8'(dones - d0), 8'h00, "no completion");
        link2.cs_n = 1'b1;
        $display("test link done");
        stop_test();
    end
endmodule : test_serial_adc_conversion_sequencer
